// ### src/ild_top.sv
// ild_top: configurable indicator leds with trigger combine, hold, clear
// assumes: trigger sources and clears are synchronous to clk_i,
// software sets each led up over a classic wishbone slave.
// Function
// - each led takes up to five selectable trigger slots, any unassigned
// - per slot polarity bit inverts that trigger before combining
// - unassigned slot always gives false, inversion ignored
// - hold mode stores the trigger-set state until a valid clear
// - hold off: led follows combined triggers with no memory
// - per-led clear source only acts while hold mode is on
// - clear releases only when all assigned triggers are inactive
// - any active trigger shows the on appearance, one of five choices
// - no active trigger and no held state shows the off appearance, same five choices
// - health led is fixed function, outside all led settings
// - live state of every slot readable at any time
// - ack also releases once quiet; hold off or all slots unassigned release at once
// - held states drop one cycle after a reset, which unassigns every slot
// - group and remote clear honoured only with external clear enabled
// - hold-with-alarm leds clear together on any protection alarm
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module ild_top #(
  parameter int NUM_LEDS = 8,
  parameter int NUM_SRC = 32,
  parameter int FLASH_CYC = ild_pkg::FLASH_HALF_CYC,
  parameter logic [31:0] ID_VALUE = 32'h0000_1234 // arbitrary value
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // trigger sources and acknowledge inputs
  input wire logic [NUM_SRC-1:0] trig_src_i,
  input wire logic group_clear_source_i,
  input wire logic operator_ack_i,
  input wire logic prot_alarm_i,
  input wire logic system_ok_i,
  // front panel leds
  output logic [NUM_LEDS-1:0] led_green_o,
  output logic [NUM_LEDS-1:0] led_red_o,
  output logic health_green_o
);
  //////////////////////////////////////////////////////////////////////////
  localparam int LW = $clog2(NUM_LEDS);
  localparam int FW = $clog2(FLASH_CYC + 1);
  localparam int SW = ild_pkg::SRC_W;
  localparam int NS = ild_pkg::NUM_SLOTS;

  // config: word A per led (slots, inversion, hold), word B (appearances, clear source)
  logic [31:0] cfga_ff [NUM_LEDS];
  logic [31:0] nxt_cfga [NUM_LEDS];
  logic [31:0] cfgb_ff [NUM_LEDS];
  logic [31:0] nxt_cfgb [NUM_LEDS];
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic [NUM_LEDS-1:0] held_ff;
  logic [NUM_LEDS-1:0] nxt_held;
  logic [NUM_LEDS-1:0] act;
  logic [NS*NUM_LEDS-1:0] slot_raw;
  logic [NUM_LEDS-1:0] green_nxt;
  logic [NUM_LEDS-1:0] red_nxt;
  logic [NUM_LEDS-1:0] green_ff;
  logic [NUM_LEDS-1:0] red_ff;
  logic [FW-1:0] fcnt_ff;
  logic [FW-1:0] nxt_fcnt;
  logic flash_ff;
  logic nxt_flash;
  logic health_ff;
  ild_pkg::ild_bus_t bus_ff;
  ild_pkg::ild_bus_t nxt_bus;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic ack_ff;
  logic nxt_ack;
  logic wr_hit;
  logic [31:0] mem_rdata;
  logic [3:0] mem_addr;

  //////////////////////////////////////////////////////////////////////////
  // per-led trigger combine, appearance and hold update
  function automatic logic [1:0] show(input logic [2:0] app,
                                      input logic flash);
    // returns {red, green}
    logic [1:0] res;
    res = 2'b00;
    unique case (app)
      ild_pkg::APP_GREEN: res = 2'b01;
      ild_pkg::APP_RED: res = 2'b10;
      ild_pkg::APP_RED_FLASH: res = {flash, 1'b0};
      ild_pkg::APP_GREEN_FLASH: res = {1'b0, flash};
      default: res = 2'b00;
    endcase
    return res;
  endfunction : show

  // group clear: external sources only when enabled; operator always
  logic grp_clr;
  assign grp_clr = operator_ack_i | (ctrl_ff[ild_pkg::CTRL_EXT_CLR_EN] &
    (group_clear_source_i | ctrl_ff[ild_pkg::CTRL_GROUP_ACK] |
     ctrl_ff[ild_pkg::CTRL_REMOTE_ACK]));

  genvar gl;
  genvar gs;
  generate
    for (gl = 0; gl < NUM_LEDS; gl++) begin : g_led
      logic [NS-1:0] eff;
      logic [NS-1:0] used;
      logic [1:0] hold;
      logic [SW-1:0] clr_sel;
      logic clr_src;
      logic [1:0] on_rgb;
      logic [1:0] off_rgb;
      logic lit;
      for (gs = 0; gs < NS; gs++) begin : g_slot
        logic [SW-1:0] sel;
        logic raw;
        assign sel = cfga_ff[gl][ild_pkg::CFG_SRC_LSB + gs*SW +: SW];
        assign used[gs] = (sel != ild_pkg::SRC_NONE);
        assign raw = used[gs] ? trig_src_i[sel] : 1'b0;
        assign slot_raw[gl*NS + gs] = raw;
        // unassigned slot stays false whatever its inversion
        assign eff[gs] = used[gs] &
          (raw ^ cfga_ff[gl][ild_pkg::CFG_INV_LSB + gs]);
      end
      assign act[gl] = |eff;
      assign hold = cfga_ff[gl][ild_pkg::CFG_HOLD_LSB +: 2];
      assign clr_sel = cfgb_ff[gl][ild_pkg::CFG_CLR_LSB +: SW];
      assign clr_src = (clr_sel != ild_pkg::SRC_NONE) & trig_src_i[clr_sel];
      // held value: set by triggers, dropped by a clear while quiet, by hold off or with no slot assigned
      always_comb begin
        nxt_held[gl] = held_ff[gl];
        if (hold == ild_pkg::HOLD_OFF || used == '0) begin
          nxt_held[gl] = 1'b0;
        end else if (act[gl]) begin
          nxt_held[gl] = 1'b1;
        end else if (clr_src || grp_clr ||
                     (hold == ild_pkg::HOLD_ON_ALARM && prot_alarm_i)) begin
          // act is low here, so every assigned trigger is quiet
          nxt_held[gl] = 1'b0;
        end
      end
      assign lit = (hold == ild_pkg::HOLD_OFF) ? act[gl]
                                              : (act[gl] | held_ff[gl]);
      assign on_rgb = show(cfgb_ff[gl][ild_pkg::CFG_ON_LSB +: 3],
                           flash_ff);
      assign off_rgb = show(cfgb_ff[gl][ild_pkg::CFG_OFF_LSB +: 3],
                            flash_ff);
      assign green_nxt[gl] = lit ? on_rgb[0] : off_rgb[0];
      assign red_nxt[gl] = lit ? on_rgb[1] : off_rgb[1];
    end
  endgenerate

  // held states carry no reset, but reset unassigns all slots so they drop a cycle later
  always_ff @(posedge clk_i) begin
    held_ff <= nxt_held;
  end

  //////////////////////////////////////////////////////////////////////////
  // shared flash divider
  always_comb begin
    nxt_fcnt = fcnt_ff + FW'(1);
    nxt_flash = flash_ff;
    if (fcnt_ff >= FW'(FLASH_CYC - 1)) begin
      nxt_fcnt = '0;
      nxt_flash = ~flash_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fcnt_ff <= '0;
      flash_ff <= 1'b0;
    end else begin
      fcnt_ff <= nxt_fcnt;
      flash_ff <= nxt_flash;
    end
  end

  // led output registers; health led follows its own fixed input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      green_ff <= '0;
      red_ff <= '0;
      health_ff <= 1'b0;
    end else begin
      green_ff <= green_nxt;
      red_ff <= red_nxt;
      health_ff <= system_ok_i;
    end
  end
  assign led_green_o = green_ff;
  assign led_red_o = red_ff;
  assign health_green_o = health_ff;

  //////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
  logic [7:0] led_off;
  logic led_hit;
  logic [LW:0] led_idx;
  logic word_b;
  assign led_off = adr_i - ild_pkg::REG_LED_BASE;
  assign led_idx = (LW+1)'(led_off[7:3]);
  assign word_b = led_off[2];
  // compare the full index so high addresses cannot alias onto led 0
  assign led_hit = (adr_i >= ild_pkg::REG_LED_BASE) &&
    (32'(led_off[7:3]) < NUM_LEDS);
  assign wr_hit = (bus_ff == ild_pkg::BUS_IDLE) & cyc_i & stb_i & we_i;
  assign mem_addr = 4'(adr_i[5:2]);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  always_comb begin
    nxt_bus = bus_ff;
    nxt_dat = dat_ff;
    nxt_ctrl = ctrl_ff;
    // one-shot clear bits self-clear after one cycle
    nxt_ctrl[ild_pkg::CTRL_GROUP_ACK] = 1'b0;
    nxt_ctrl[ild_pkg::CTRL_REMOTE_ACK] = 1'b0;
    for (int i = 0; i < NUM_LEDS; i++) begin
      nxt_cfga[i] = cfga_ff[i];
      nxt_cfgb[i] = cfgb_ff[i];
    end
    unique case (bus_ff)
      ild_pkg::BUS_IDLE: begin
        if (cyc_i && stb_i) begin
          nxt_bus = ild_pkg::BUS_ACK;
          nxt_dat = 32'h0000_0000;
          if (adr_i == ild_pkg::REG_CTRL) begin
            nxt_dat = {29'h0, 2'h0, ctrl_ff[ild_pkg::CTRL_EXT_CLR_EN]};
            if (we_i) nxt_ctrl = merge(ctrl_ff, dat_i, sel_i);
          end else if (adr_i == ild_pkg::REG_STATUS) begin
            nxt_dat = 32'(held_ff);
          end else if (adr_i == ild_pkg::REG_RAW) begin
            nxt_dat = 32'(slot_raw);
          end else if (adr_i == ild_pkg::REG_RAW_HI) begin
            // upper slot states, so every slot stays readable
            nxt_dat = 32'(slot_raw >> $bits(nxt_dat));
          end else if (adr_i == ild_pkg::REG_ID) begin
            nxt_dat = ID_VALUE;
          end else if (led_hit) begin
            if (word_b) begin
              nxt_dat = cfgb_ff[led_idx[LW-1:0]];
              if (we_i) nxt_cfgb[led_idx[LW-1:0]] =
                merge(cfgb_ff[led_idx[LW-1:0]], dat_i, sel_i);
            end else begin
              nxt_dat = cfga_ff[led_idx[LW-1:0]];
              if (we_i) nxt_cfga[led_idx[LW-1:0]] =
                merge(cfga_ff[led_idx[LW-1:0]], dat_i, sel_i);
            end
          end
        end
      end
      ild_pkg::BUS_ACK: nxt_bus = ild_pkg::BUS_IDLE;
      default: nxt_bus = ild_pkg::BUS_IDLE;
    endcase
    // ack gets its own flop so the port has no decode behind it
    nxt_ack = (nxt_bus == ild_pkg::BUS_ACK);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_ff <= ild_pkg::BUS_IDLE;
      ack_ff <= 1'b0;
      dat_ff <= ild_pkg::RESET_VAL;
      ctrl_ff <= ild_pkg::RESET_VAL;
      for (int i = 0; i < NUM_LEDS; i++) begin
        cfga_ff[i] <= ild_pkg::RESET_VAL;
        cfgb_ff[i] <= ild_pkg::RESET_VAL;
      end
    end else begin
      bus_ff <= nxt_bus;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      ctrl_ff <= nxt_ctrl;
      for (int i = 0; i < NUM_LEDS; i++) begin
        cfga_ff[i] <= nxt_cfga[i];
        cfgb_ff[i] <= nxt_cfgb[i];
      end
    end
  end
  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  // scratch shadow of every bus write; its mem_rdata is never read back
  ild_cfg_mem #(.DEPTH(16), .AW(4)) u_shadow (
    .clk_i(clk_i),
    .we_i(wr_hit),
    .waddr_i(mem_addr),
    .wdata_i(dat_i),
    .raddr_i(mem_addr),
    .rdata_o(mem_rdata)
  );
endmodule : ild_top

// ### src/ild_pkg.sv
// ild_pkg: constants and types shared by the indicator led latch logic
// assumes: one 40 MHz system clock, synchronous active-high reset
package ild_pkg;
  // per-led trigger slot count
  localparam int NUM_SLOTS = 5;
  // trigger source select width, code 0 means slot unassigned
  localparam int SRC_W = 5;
  localparam logic [4:0] SRC_NONE = 5'h00;
  // appearance codes for the on and off conditions
  localparam logic [2:0] APP_OFF = 3'h0;
  localparam logic [2:0] APP_GREEN = 3'h1;
  localparam logic [2:0] APP_RED = 3'h2;
  localparam logic [2:0] APP_RED_FLASH = 3'h3;
  localparam logic [2:0] APP_GREEN_FLASH = 3'h4;
  // hold mode codes
  localparam logic [1:0] HOLD_OFF = 2'h0;
  localparam logic [1:0] HOLD_ON = 2'h1;
  localparam logic [1:0] HOLD_ON_ALARM = 2'h2;
  // timing: flash half period in ms and clock rate
  localparam int CLK_HZ = 40000000;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  // register map, byte addresses on the wishbone slave
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RAW = 8'h08;
  localparam logic [7:0] REG_ID = 8'h0c;
  // slot states beyond the first 32 bits spill into this word
  localparam logic [7:0] REG_RAW_HI = 8'h10;
  localparam logic [7:0] REG_LED_BASE = 8'h40;
  localparam logic [7:0] REG_LED_STRIDE = 8'h04;
  // ctrl fields
  localparam int CTRL_EXT_CLR_EN = 0;
  localparam int CTRL_GROUP_ACK = 1;
  localparam int CTRL_REMOTE_ACK = 2;
  // per-led config word layout
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_INV_LSB = 25;
  localparam int CFG_HOLD_LSB = 30;
  localparam int CFG_ON_LSB = 0;
  localparam int CFG_OFF_LSB = 3;
  localparam int CFG_CLR_LSB = 6;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
  // state of the wishbone slave
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } ild_bus_t;
endpackage : ild_pkg

// ### src/ild_cfg_mem.sv
// ild_cfg_mem: small config store, one word per entry, registered read
// assumes: single clock, contents survive a logic reset (no reset on array)
`timescale 1ns/100ps
module ild_cfg_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [31:0] wdata_i,
  // read port
  input wire logic [AW-1:0] raddr_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem_ff [DEPTH];
  logic [31:0] rdata_ff;

  // write and registered read
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
    rdata_ff <= mem_ff[raddr_i];
  end
  assign rdata_o = rdata_ff;
endmodule : ild_cfg_mem

// ### bench/ild_src_model.sv
// ild_src_model: far-side trigger, ack, alarm and health sources
// assumes: bench requests change just after a rising edge of clk_i
`timescale 1ns/100ps
module ild_src_model #(
  parameter int NUM_SRC = 32
) (
  // clock
  input wire logic clk_i,
  // requests from the bench
  input wire logic [NUM_SRC-1:0] trig_req_i,
  input wire logic [3:0] ctl_req_i,
  // source levels towards the block
  output logic [NUM_SRC-1:0] trig_src_o,
  output logic [3:0] ctl_o
);
  // one register stage, so sources really are synchronous to clk_i
  always_ff @(posedge clk_i) begin
    trig_src_o <= trig_req_i;
    ctl_o <= ctl_req_i; // group, operator, alarm, health
  end
endmodule : ild_src_model

// ### bench/ild_top_properties.sv
// ild_top_properties: port-level checks of the indicator led block
// assumes: bound into ild_top, one clock, synchronous reset
`timescale 1ns/100ps
module ild_top_properties #(
  parameter int NUM_LEDS = 8,
  parameter logic [31:0] ID_VALUE = 32'h0000_1234 // arbitrary value
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // indicators
  input wire logic system_ok_i,
  input wire logic [NUM_LEDS-1:0] led_green_o,
  input wire logic [NUM_LEDS-1:0] led_red_o,
  input wire logic health_green_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  ack_latency_a: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  ack_pulse_a: assert property (
    ack_o |=> !ack_o) else $error("ack held");
  ack_cause_a: assert property (
    ack_o |-> $past(cyc_i && stb_i)) else $error("ack unasked");
  unmapped_zero_a: assert property (
    ack_o && !$past(we_i) && $past(adr_i) inside {[8'h14:8'h3c]}
    |-> dat_o == 32'h0) else $error("unmapped read not zero");
  id_read_a: assert property (
    ack_o && !$past(we_i) && $past(adr_i) == 8'h0c
    |-> dat_o == ID_VALUE) else $error("id read wrong");
  health_copy_a: assert property (
    $past(!rst_i) |-> health_green_o == $past(system_ok_i))
    else $error("health led not copied");
  colour_excl_a: assert property (
    (led_green_o & led_red_o) == '0) else $error("two colours lit");
  // reset itself is the cause here, so this one is not disabled by it
  reset_dark_a: assert property (disable iff (1'b0)
    rst_i |=> !ack_o && led_green_o == '0 && led_red_o == '0)
    else $error("not dark after reset");
endmodule : ild_top_properties

bind ild_top ild_top_properties #(.NUM_LEDS(NUM_LEDS),
  .ID_VALUE(ID_VALUE)) ild_top_properties_inst (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .system_ok_i(system_ok_i), .led_green_o(led_green_o),
  .led_red_o(led_red_o), .health_green_o(health_green_o));

// ### bench/ild_top_bench.sv
// ild_top_bench: register-driven tests of the indicator led block
// assumes: short flash period, sources come through ild_src_model
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module ild_top_bench;
  localparam int FC = 4;
  localparam logic [31:0] IDV = 32'h0000_5a5a; // arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, health_green_o;
  logic [7:0] adr_i = 8'h00, led_green_o, led_red_o;
  logic [31:0] dat_i = 32'h0, dat_o, rd, trig_req = 32'h0, trig_src;
  logic [3:0] ctl_req = 4'h0, ctl;
  int bad_count = 0, cmp_count = 0, cyc_n = 0;
  ild_top #(.FLASH_CYC(FC), .ID_VALUE(IDV)) ild_top_inst (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .trig_src_i(trig_src), .group_clear_source_i(ctl[0]),
    .operator_ack_i(ctl[1]), .prot_alarm_i(ctl[2]), .system_ok_i(ctl[3]),
    .led_green_o(led_green_o), .led_red_o(led_red_o),
    .health_green_o(health_green_o));
  ild_src_model ild_src_model_inst (.clk_i(clk_i), .trig_req_i(trig_req),
    .ctl_req_i(ctl_req), .trig_src_o(trig_src), .ctl_o(ctl));
  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_c
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask : wb
  task automatic led1(input logic g, input logic r);
    wait_c(4);
    `CHK({led_green_o[1], led_red_o[1]}, {g, r})
  endtask : led1
  // trigger led 1 once, drop the trigger and expect it held red
  task automatic latch();
    trig_req <= 32'h40;
    wait_c(4);
    trig_req <= 32'h0;
    led1(1'b0, 1'b1);
  endtask : latch
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic eg, ag, er, ar;
    logic [3:0] ex;
    wait_c(12);
    rst_i <= 1'b0;
    ctl_req <= 4'h8;
    wb(1'b0, 8'h0c, 32'h0);
    `CHK(rd, IDV)
    wb(1'b1, 8'h20, 32'hffff_ffff);
    wb(1'b0, 8'h20, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b1, 8'hc0, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(health_green_o, 1'b1)
    $display("test registers done");
    // led 0: slot0 src1, slot1 src2 inverted, idle slots inverted too
    wb(1'b1, 8'h40, 32'h3c00_0041);
    wb(1'b1, 8'h44, 32'h0000_000a);
    wait_c(4);
    `CHK({led_green_o[0], led_red_o[0]}, 2'b01)
    trig_req <= 32'h4;
    wait_c(4);
    `CHK({led_green_o[0], led_red_o[0]}, 2'b10)
    trig_req <= 32'h6;
    wb(1'b0, 8'h08, 32'h0);
    `CHK(rd & 32'h1d, 32'h1)
    // led 7 slot0 on src2: its state lands in the upper raw word
    wb(1'b1, 8'h78, 32'h0000_0002);
    wb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h8)
    for (int c = 0; c < 5; c++) begin
      for (int ph = 0; ph < 2; ph++) begin
        trig_req <= ph ? 32'h4 : 32'h0;
        wb(1'b1, 8'h44, 32'(c) << (3 * ph));
        wait_c(4);
        {eg, ag, er, ar} = 4'b0101;
        repeat (4 * FC) begin
          @(posedge clk_i);
          {eg, er} = {eg | led_green_o[0], er | led_red_o[0]};
          {ag, ar} = {ag & led_green_o[0], ar & led_red_o[0]};
        end
        ex = {c == 1 || c == 4, c == 1, c == 2 || c == 3, c == 2};
        `CHK({eg, ag, er, ar}, ex)
      end
    end
    $display("test appearance done");
    // led 1: slot0 src6, hold on, clear by src7, red when on
    wb(1'b1, 8'h48, 32'h4000_0006);
    wb(1'b1, 8'h4c, 32'h0000_01c2);
    latch();
    wb(1'b0, 8'h04, 32'h0);
    `CHK(rd[1], 1'b1)
    trig_req <= 32'hc0;
    led1(1'b0, 1'b1);
    trig_req <= 32'h80;
    led1(1'b0, 1'b0);
    latch();
    ctl_req <= 4'h9;
    led1(1'b0, 1'b1);
    wb(1'b1, 8'h00, 32'h1);
    led1(1'b0, 1'b0);
    ctl_req <= 4'h8;
    latch();
    wb(1'b1, 8'h00, 32'h4);
    led1(1'b0, 1'b1);
    wb(1'b1, 8'h00, 32'h5);
    led1(1'b0, 1'b0);
    latch();
    ctl_req <= 4'ha;
    led1(1'b0, 1'b0);
    ctl_req <= 4'h8;
    latch();
    wb(1'b1, 8'h00, 32'h3);
    led1(1'b0, 1'b0);
    latch();
    wb(1'b1, 8'h48, 32'h0000_0006);
    led1(1'b0, 1'b0);
    wb(1'b1, 8'h48, 32'h8000_0006);
    latch();
    ctl_req <= 4'hc;
    led1(1'b0, 1'b0);
    ctl_req <= 4'h8;
    wb(1'b1, 8'h48, 32'h4000_0006);
    latch();
    wb(1'b1, 8'h48, 32'h4000_0000);
    led1(1'b0, 1'b0);
    $display("test hold done");
    stop_test();
  end
endmodule : ild_top_bench
